// ==== include/bsc_consts.svh ====
// Opcode patterns, field positions, reset values for the bit/call/clear decoder.
// Assumes a 14-bit instruction word and an 8-bit data path.
//
// Contract
// - Decode the skip-if-set opcode with 3-bit bit index and 6-bit file address.
// - A set tested bit discards the next fetched word, giving a two-cycle test.
// - A call pushes the current program counter plus one onto the stack top.
// - After the push, a call loads its 12-bit target into PC bits 11..0.
// - Every call takes exactly two instruction cycles.
// - Clear-file writes 00h to the addressed register, sets zero, one cycle.
// - Clear-accumulator writes zero to the accumulator, sets zero, one cycle.
// - Watchdog clear resets the watchdog/wakeup counter to zero in one cycle.
// - Invert-file forms the bitwise inverse of the addressed register, one cycle.
// - Destination bit zero sends result to accumulator, one writes it back.
`ifndef BSC_CONSTS_SVH
`define BSC_CONSTS_SVH

// ==================================================
// Opcode masks and match values
`define OPC_SKIP_MASK   14'h3E00
`define OPC_SKIP_MATCH  14'h1600
`define OPC_CALL_MASK   14'h3000
`define OPC_CALL_MATCH  14'h2000
`define OPC_CLEAR_FILE_REG_MASK   14'h3F80
`define OPC_CLEAR_FILE_REG_MATCH  14'h0180
`define OPC_CLEAR_ACCUMULATOR_WORD   14'h0140
`define OPC_WDTCLR_WORD 14'h0004
`define OPC_INVF_MASK   14'h3F00
`define OPC_INVF_MATCH  14'h0900

// ==================================================
// Field positions
`define FLD_BIT_HI      8
`define FLD_BIT_LO      6
`define FLD_F6_HI       5
`define FLD_F7_HI       6
`define FLD_DEST        7
`define FLD_K_HI        11

// ==================================================
// Reset values
`define PC_RST          12'h000
`define ACC_RST         8'h00
`define ZERO_RST        1'b0
`define TO_RST          1'b1
`define PD_RST          1'b1
`define FILE_CLR_VAL    8'h00

`endif

// ==== include/bsc_pkg.sv ====
// Types shared by the decoder and the execute core.
// Assumes one-hot encodings throughout.
package bsc_pkg;

   // ==================================================
   // Instruction classes
   typedef enum logic [6:0]
   {
      OP_OTHER  = 7'h01,
      OP_SKIP   = 7'h02,
      OP_CALL   = 7'h04,
      OP_CLEAR_FILE_REG   = 7'h08,
      OP_CLEAR_ACCUMULATOR   = 7'h10,
      OP_WDTCLR = 7'h20,
      OP_INVF   = 7'h40
   } op_kind_e;

   // ==================================================
   // Execute states
   typedef enum logic [1:0]
   {
      ST_EXEC  = 2'h1,
      ST_FLUSH = 2'h2
   } exec_state_e;

endpackage : bsc_pkg

// ==== include/decode_if.sv ====
// Carrier between the instruction decoder and the execute core.
// Assumes the decoder is purely combinational.
`timescale 1ns/1ps
interface decode_if;
   import bsc_pkg::*;

   logic [13:0]     word;
   op_kind_e        kind;
   logic [2:0]      bit_sel;
   logic [6:0]      faddr;
   logic            dest;
   logic [11:0]     target;

   modport dec  (input word, output kind, bit_sel, faddr, dest, target);
   modport core (output word, input kind, bit_sel, faddr, dest, target);
endinterface : decode_if

// ==== core/instr_decode.sv ====
// Combinational opcode classifier and field extractor.
// Assumes the word on the interface is the instruction being executed.
`timescale 1ns/1ps
`include "bsc_consts.svh"
module instr_decode
(
   decode_if.dec    dif
);
   import bsc_pkg::*;

   // ==================================================
   // Classification
   function automatic op_kind_e classify(input logic [13:0] w);
      op_kind_e k;
      k = OP_OTHER;
      if ((w & `OPC_SKIP_MASK) == `OPC_SKIP_MATCH)
         k = OP_SKIP;
      else if ((w & `OPC_CALL_MASK) == `OPC_CALL_MATCH)
         k = OP_CALL;
      else if ((w & `OPC_CLEAR_FILE_REG_MASK) == `OPC_CLEAR_FILE_REG_MATCH)
         k = OP_CLEAR_FILE_REG;
      else if (w == `OPC_CLEAR_ACCUMULATOR_WORD)
         k = OP_CLEAR_ACCUMULATOR;
      else if (w == `OPC_WDTCLR_WORD)
         k = OP_WDTCLR;
      else if ((w & `OPC_INVF_MASK) == `OPC_INVF_MATCH)
         k = OP_INVF;
      return k;
   endfunction : classify

   // ==================================================
   // Fields
   always_comb
   begin
      dif.kind    = classify(dif.word);
      dif.bit_sel = dif.word[`FLD_BIT_HI:`FLD_BIT_LO];
      // Bit-oriented ops reach only the low 64 file addresses
      if (dif.kind == OP_SKIP)
         dif.faddr = {1'b0, dif.word[`FLD_F6_HI:0]};
      else
         dif.faddr = dif.word[`FLD_F7_HI:0];
      dif.dest    = dif.word[`FLD_DEST];
      dif.target  = dif.word[`FLD_K_HI:0];
   end

endmodule : instr_decode

// ==== core/bit_skip_call_clear_ops.sv ====
// Execute core for skip-if-set, call, clear-file, clear-accumulator,
// watchdog clear and invert-file.
// Assumes instr_in is the word at pc_out and file_rdata_in answers
// file_raddr_out in the same cycle; all inputs are on clk_sys_in.
`timescale 1ns/1ps
`include "bsc_consts.svh"
module bit_skip_call_clear_ops
#(
   parameter int WDT_W = 8
)
(
   input  wire logic             clk_sys_in,
   input  wire logic             nrst_in,
   input  wire logic [13:0]      instr_in,
   input  wire logic             instr_valid_in,
   input  wire logic [7:0]       file_rdata_in,
   input  wire logic             wdt_tick_in,
   output logic      [6:0]       file_raddr_out,
   output logic                  file_we_out,
   output logic      [6:0]       file_waddr_out,
   output logic      [7:0]       file_wdata_out,
   output logic      [7:0]       acc_out,
   output logic                  zero_flag_out,
   output logic                  time_out_flag_out,
   output logic                  sleep_flag_out,
   output logic      [11:0]      pc_out,
   output logic      [11:0]      stack_top_out,
   output logic                  stack_push_out,
   output logic      [WDT_W-1:0] watchdog_counter_out,
   output logic                  busy_out,
   output logic                  other_op_out
);
   import bsc_pkg::*;

   // ==================================================
   // Decoder
   decode_if dif ();

   instr_decode u_dec
   (
      .dif (dif)
   );

   assign dif.word = instr_in;

   function automatic logic [11:0] next_pc(input logic [11:0] p);
      return p + 12'h001;
   endfunction : next_pc

   // ==================================================
   // State
   exec_state_e      state_r,      state_nxt;
   logic [11:0]      pc_r,         pc_nxt;
   logic [11:0]      stack_top_r,  stack_top_nxt;
   logic             push_r,       push_nxt;
   logic             flush_inc_r,  flush_inc_nxt;
   logic [7:0]       acc_r,        acc_nxt;
   logic             zero_r,       zero_nxt;
   logic             to_r,         to_nxt;
   logic             pd_r,         pd_nxt;
   logic [WDT_W-1:0] wdt_r,        wdt_nxt;
   logic             we_r,         we_nxt;
   logic [6:0]       waddr_r,      waddr_nxt;
   logic [7:0]       wdata_r,      wdata_nxt;
   logic             go;
   logic [7:0]       inv_val;

   assign go      = (state_r == ST_EXEC) && instr_valid_in;
   assign inv_val = ~file_rdata_in;

   // ==================================================
   // Next-state logic
   always_comb
   begin
      state_nxt     = ST_EXEC;
      pc_nxt        = pc_r;
      stack_top_nxt = stack_top_r;
      push_nxt      = 1'b0;
      flush_inc_nxt = flush_inc_r;
      acc_nxt       = acc_r;
      zero_nxt      = zero_r;
      to_nxt        = to_r;
      pd_nxt        = pd_r;
      we_nxt        = 1'b0;
      waddr_nxt     = waddr_r;
      wdata_nxt     = wdata_r;
      // Clear beats a tick landing in the same cycle
      wdt_nxt       = wdt_tick_in ? wdt_r + {{(WDT_W-1){1'b0}}, 1'b1} : wdt_r;
      case (state_r)
         ST_EXEC:
         begin
            if (go)
            begin
               pc_nxt = next_pc(pc_r);
               case (dif.kind)
                  OP_SKIP:
                  begin
                     if (file_rdata_in[dif.bit_sel])
                     begin
                        state_nxt     = ST_FLUSH;
                        flush_inc_nxt = 1'b1;
                     end
                  end
                  OP_CALL:
                  begin
                     stack_top_nxt = next_pc(pc_r);
                     push_nxt      = 1'b1;
                     pc_nxt        = dif.target;
                     state_nxt     = ST_FLUSH;
                     flush_inc_nxt = 1'b0;
                  end
                  OP_CLEAR_FILE_REG:
                  begin
                     we_nxt    = 1'b1;
                     waddr_nxt = dif.faddr;
                     wdata_nxt = `FILE_CLR_VAL;
                     zero_nxt  = 1'b1;
                  end
                  OP_CLEAR_ACCUMULATOR:
                  begin
                     acc_nxt  = `ACC_RST;
                     zero_nxt = 1'b1;
                  end
                  OP_WDTCLR:
                  begin
                     wdt_nxt = '0;
                     to_nxt  = 1'b1;
                     pd_nxt  = 1'b1;
                  end
                  OP_INVF:
                  begin
                     zero_nxt = (inv_val == 8'h00);
                     if (dif.dest)
                     begin
                        we_nxt    = 1'b1;
                        waddr_nxt = dif.faddr;
                        wdata_nxt = inv_val;
                     end
                     else
                     begin
                        acc_nxt = inv_val;
                     end
                  end
                  default:
                  begin
                     pc_nxt = next_pc(pc_r);
                  end
               endcase
            end
         end
         ST_FLUSH:
         begin
            // Fetched word is thrown away; this cycle is a no-operation
            if (flush_inc_r)
               pc_nxt = next_pc(pc_r);
            state_nxt = ST_EXEC;
         end
         default:
         begin
            state_nxt = ST_EXEC;
         end
      endcase
   end

   // ==================================================
   // Registers
   always_ff @(posedge clk_sys_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         state_r     <= ST_EXEC;
         pc_r        <= `PC_RST;
         stack_top_r <= `PC_RST;
         push_r      <= 1'b0;
         flush_inc_r <= 1'b0;
         acc_r       <= `ACC_RST;
         zero_r      <= `ZERO_RST;
         to_r        <= `TO_RST;
         pd_r        <= `PD_RST;
         wdt_r       <= '0;
         we_r        <= 1'b0;
         waddr_r     <= 7'h00;
         wdata_r     <= 8'h00;
      end
      else
      begin
         state_r     <= state_nxt;
         pc_r        <= pc_nxt;
         stack_top_r <= stack_top_nxt;
         push_r      <= push_nxt;
         flush_inc_r <= flush_inc_nxt;
         acc_r       <= acc_nxt;
         zero_r      <= zero_nxt;
         to_r        <= to_nxt;
         pd_r        <= pd_nxt;
         wdt_r       <= wdt_nxt;
         we_r        <= we_nxt;
         waddr_r     <= waddr_nxt;
         wdata_r     <= wdata_nxt;
      end
   end

   // ==================================================
   // Outputs
   // Read address is combinational so the operand arrives in the same cycle
   assign file_raddr_out       = dif.faddr;
   assign file_we_out          = we_r;
   assign file_waddr_out       = waddr_r;
   assign file_wdata_out       = wdata_r;
   assign acc_out              = acc_r;
   assign zero_flag_out        = zero_r;
   assign time_out_flag_out    = to_r;
   assign sleep_flag_out       = pd_r;
   assign pc_out               = pc_r;
   assign stack_top_out        = stack_top_r;
   assign stack_push_out       = push_r;
   assign watchdog_counter_out = wdt_r;
   assign busy_out             = (state_r == ST_FLUSH);
   assign other_op_out         = go && (dif.kind == OP_OTHER);

   // ==================================================
   // Checks
   a_skip_taken: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      go && dif.kind == OP_SKIP && file_rdata_in[dif.bit_sel]
      |=> busy_out && pc_out == $past(pc_r) + 12'h001 ##1 !busy_out
          && pc_out == $past(pc_r, 2) + 12'h002)
      else $error("skip did not discard the next word");

   a_skip_not_taken: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      go && dif.kind == OP_SKIP && !file_rdata_in[dif.bit_sel]
      |=> !busy_out && pc_out == $past(pc_r) + 12'h001)
      else $error("clear bit caused a skip");

   a_call_push: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      go && dif.kind == OP_CALL
      |=> stack_push_out && stack_top_out == $past(pc_r) + 12'h001)
      else $error("call pushed wrong return address");

   a_call_target: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      go && dif.kind == OP_CALL |=> pc_out == $past(instr_in[11:0]) ##1 pc_out == $past(pc_r))
      else $error("call target not loaded");

   a_call_cycles: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      go && dif.kind == OP_CALL |=> busy_out ##1 !busy_out)
      else $error("call did not take two cycles");

   a_clear_file_reg_write: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      go && dif.kind == OP_CLEAR_FILE_REG
      |=> file_we_out && file_wdata_out == 8'h00
          && file_waddr_out == $past(instr_in[6:0]) && zero_flag_out)
      else $error("clear-file failed");

   a_clear_accumulator_acc: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      go && dif.kind == OP_CLEAR_ACCUMULATOR |=> acc_out == 8'h00 && zero_flag_out && !file_we_out)
      else $error("clear-accumulator failed");

   a_wdt_clear: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      go && dif.kind == OP_WDTCLR |=> watchdog_counter_out == '0)
      else $error("watchdog counter not cleared");

   a_wdt_flags: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      go && dif.kind == OP_WDTCLR |=> time_out_flag_out && sleep_flag_out)
      else $error("status flags not set by watchdog clear");

   a_invf_acc: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      go && dif.kind == OP_INVF && !dif.dest
      |=> acc_out == ~$past(file_rdata_in) && !file_we_out)
      else $error("invert to accumulator failed");

   a_invf_file: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      go && dif.kind == OP_INVF && dif.dest
      |=> file_we_out && file_wdata_out == ~$past(file_rdata_in)
          && acc_out == $past(acc_r))
      else $error("invert write-back failed");

   a_invf_zero: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      go && dif.kind == OP_INVF |=> zero_flag_out == ($past(file_rdata_in) == 8'hFF))
      else $error("invert zero flag wrong");

endmodule : bit_skip_call_clear_ops

// ==== tb/tb_top.sv ====
// Self-checking bench for the bit/call/clear execute core.
// Assumes the bench plays fetch and register file; rdata is the bench's own pick.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_top;
   import bsc_pkg::*;

   // ==================================================
   // Design ports
   logic        clk_sys_in, nrst_in, instr_valid_in, wdt_tick_in;
   logic [13:0] instr_in;
   logic [7:0]  file_rdata_in, file_wdata_out, acc_out, watchdog_counter_out;
   logic [6:0]  file_raddr_out, file_waddr_out;
   logic [11:0] pc_out, stack_top_out;
   logic        file_we_out, zero_flag_out, time_out_flag_out, sleep_flag_out;
   logic        stack_push_out, busy_out, other_op_out;

   // ==================================================
   // Expected state, updated by the bench alone
   logic [11:0] pc_e, st_e;
   logic [7:0]  acc_e, cnt_e, wd_e;
   logic [6:0]  wa_e;
   logic        z_e, we_e, push_e, busy_e, disc;
   int          compares, bad_count;

   bit_skip_call_clear_ops #(.WDT_W(8)) i_bit_skip_call_clear_ops
   (
      .clk_sys_in           (clk_sys_in),
      .nrst_in              (nrst_in),
      .instr_in             (instr_in),
      .instr_valid_in       (instr_valid_in),
      .file_rdata_in        (file_rdata_in),
      .wdt_tick_in          (wdt_tick_in),
      .file_raddr_out       (file_raddr_out),
      .file_we_out          (file_we_out),
      .file_waddr_out       (file_waddr_out),
      .file_wdata_out       (file_wdata_out),
      .acc_out              (acc_out),
      .zero_flag_out        (zero_flag_out),
      .time_out_flag_out    (time_out_flag_out),
      .sleep_flag_out       (sleep_flag_out),
      .pc_out               (pc_out),
      .stack_top_out        (stack_top_out),
      .stack_push_out       (stack_push_out),
      .watchdog_counter_out (watchdog_counter_out),
      .busy_out             (busy_out),
      .other_op_out         (other_op_out)
   );

   initial
   begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   // ==================================================
   // Counter model; a discarded word must never clear it
   always @(posedge clk_sys_in or negedge nrst_in)
      if (!nrst_in) cnt_e <= 8'h00;
      else if (instr_valid_in & !disc & (instr_in == 14'h0004)) cnt_e <= 8'h00;
      else if (wdt_tick_in) cnt_e <= cnt_e + 8'h01;

   always @(posedge clk_sys_in)
      wdt_tick_in <= 1'($urandom_range(0, 1));

   // ==================================================
   // Helpers
   function automatic logic [13:0] mk(input int k, input logic [13:0] f);
      case (k)
         0:       mk = {5'b01011, f[8:0]};
         1:       mk = {2'b10, f[11:0]};
         2:       mk = {7'b0000011, f[6:0]};
         3:       mk = 14'h0140;
         4:       mk = 14'h0004;
         5:       mk = {6'b001001, f[7:0]};
         default: mk = f;
      endcase
   endfunction : mk

   task automatic model_reset();
      pc_e   = 12'h000;
      st_e   = 12'h000;
      acc_e  = 8'h00;
      z_e    = 1'b0;
      we_e   = 1'b0;
      push_e = 1'b0;
      busy_e = 1'b0;
   endtask : model_reset

   task automatic check_all();
      `CHK("pc", pc_e, pc_out)
      `CHK("stack_top", st_e, stack_top_out)
      `CHK("acc", acc_e, acc_out)
      `CHK("zero", z_e, zero_flag_out)
      `CHK("counter", cnt_e, watchdog_counter_out)
      `CHK("time_out", 1'b1, time_out_flag_out)
      `CHK("sleep", 1'b1, sleep_flag_out)
      `CHK("busy", busy_e, busy_out)
      `CHK("push", push_e, stack_push_out)
      `CHK("we", we_e, file_we_out)
      if (we_e)
      begin
         `CHK("waddr", wa_e, file_waddr_out)
         `CHK("wdata", wd_e, file_wdata_out)
      end
   endtask : check_all

   // Entered at a clock edge; returns at the edge where the next word may go in.
   // Results of a one-cycle op are checked by the following call, hence a final idle check_all.
   task automatic run(input logic [13:0] w, input logic [7:0] r, input logic v);
      logic       skp, cal, clf, clw, inv, tk;
      logic [7:0] res;
      skp = (w[13:9] == 5'b01011);
      cal = (w[13:12] == 2'b10);
      clf = (w[13:7] == 7'b0000011);
      clw = (w == 14'h0140);
      inv = (w[13:8] == 6'b001001);
      tk  = skp & r[w[8:6]];
      res = ~r;
      instr_in       <= w;
      instr_valid_in <= v;
      file_rdata_in  <= r;
      @(negedge clk_sys_in);
      check_all();
      `CHK("raddr", skp ? {1'b0, w[5:0]} : w[6:0], file_raddr_out)
      `CHK("other", v & !(skp | cal | clf | clw | inv | (w == 14'h0004)), other_op_out)
      we_e   = v & (clf | (inv & w[7]));
      wa_e   = w[6:0];
      wd_e   = clf ? 8'h00 : res;
      push_e = v & cal;
      busy_e = v & (tk | cal);
      if (v)
      begin
         if (cal) st_e = pc_e + 12'h001;
         pc_e = cal ? w[11:0] : pc_e + 12'h001;
         if (clf | clw) z_e = 1'b1;
         if (inv) z_e = (res == 8'h00);
         if (clw) acc_e = 8'h00;
         if (inv & !w[7]) acc_e = res;
      end
      @(posedge clk_sys_in);
      if (busy_e)
      begin
         instr_in <= 14'($urandom);
         disc     <= 1'b1;
         @(negedge clk_sys_in);
         check_all();
         @(posedge clk_sys_in);
         disc <= 1'b0;
         busy_e = 1'b0;
         push_e = 1'b0;
         we_e   = 1'b0;
         if (tk) pc_e = pc_e + 12'h001;
      end
   endtask : run

   task automatic random_runs(input int n);
      repeat (n) run(mk($urandom_range(0, 7), 14'($urandom)), 8'($urandom),
                     1'($urandom_range(0, 7) != 0));
   endtask : random_runs

   task automatic finish_test();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test

   // ==================================================
   // Watchdog: the run needs some 1,000 cycles
   initial
   begin
      #(20000 * 10);
      bad_count++;
      finish_test();
   end

   initial
   begin
      void'($urandom(32'h6A109EA6));
      nrst_in        = 1'b0;
      instr_in       = 14'h0000;
      instr_valid_in = 1'b0;
      file_rdata_in  = 8'h00;
      disc           = 1'b0;
      compares       = 0;
      bad_count      = 0;
      model_reset();
      repeat (15) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      check_all();
      @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      // Corners: call to the top address so pc wraps, both skip outcomes, zero results
      run(mk(1, 14'h0FFF), 8'h00, 1'b1);
      run(mk(0, 14'h01FF), 8'h80, 1'b1);
      run(mk(0, 14'h0001), 8'hFE, 1'b1);
      run(mk(5, 14'h00FF), 8'hFF, 1'b1);
      run(mk(5, 14'h0012), 8'h00, 1'b1);
      run(mk(2, 14'h007F), 8'h5A, 1'b1);
      run(mk(3, 14'h0000), 8'h00, 1'b1);
      run(mk(4, 14'h0000), 8'h00, 1'b1);
      run(14'h3FFF, 8'h00, 1'b1);
      run(mk(1, 14'h0000), 8'h00, 1'b1);
      run(mk(3, 14'h0000), 8'h00, 1'b0);
      random_runs(500);
      // Second reset in mid-run
      nrst_in        <= 1'b0;
      instr_valid_in <= 1'b0;
      model_reset();
      @(negedge clk_sys_in);
      check_all();
      repeat (2) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      random_runs(300);
      instr_valid_in <= 1'b0;
      @(negedge clk_sys_in);
      check_all();
      finish_test();
   end
endmodule : tb_top
